// [logic/eir_pkg.sv]
package eir_pkg;
    // register offsets are word indices; byte address is index * 4
    localparam logic [7:0] IDX_EXTENDED_FLAGS     = 8'h91;
    localparam logic [7:0] IDX_STANDARD_ENABLES   = 8'ha8;
    localparam logic [7:0] IDX_STANDARD_LEVELS    = 8'hb8;
    localparam logic [7:0] IDX_WAKE_FLAG_CONTROL  = 8'hd8;
    localparam logic [7:0] IDX_EXTENDED_ENABLES   = 8'he8;
    localparam logic [7:0] IDX_EXTENDED_LEVELS    = 8'hf8;
    localparam logic [7:0] IDX_PENDING_STATUS     = 8'hfc;

    // field positions
    localparam int POS_GLOBAL_GATE  = 7;
    localparam int POS_WAKE_FLAG    = 3;

    // writable masks and fixed read values
    localparam logic [7:0] STD_EN_WMASK   = 8'hbf;
    localparam logic [7:0] STD_LVL_WMASK  = 8'h3f;
    localparam logic [7:0] STD_LVL_ONES   = 8'h80;
    localparam logic [7:0] EXT_FLAG_WMASK = 8'hf0;
    localparam logic [7:0] EXT_FLAG_ONES  = 8'h08;
    localparam logic [7:0] WAKE_WMASK     = 8'h08;
    localparam logic [7:0] WAKE_ONES      = 8'h40;
    localparam logic [7:0] EXT_EN_WMASK   = 8'h1f;
    localparam logic [7:0] EXT_ONES       = 8'he0;

    // reset values
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [3:0] NO_SOURCE      = 4'hf;

    // natural order of the eleven sources, index 0 wins ties
    localparam int NUM_SRC = 11;
endpackage

// [logic/eir_top.sv]
`timescale 1ns/1ps
module eir_top
    import eir_pkg::*;
(
    input  wire logic        I_CLK,              // cpu clock, 10 MHz
    input  wire logic        I_RSTN,             // async reset, low
    input  wire logic        I_WB_CYC,           // bus cycle
    input  wire logic        I_WB_STB,           // bus strobe
    input  wire logic        I_WB_WE,            // write enable
    input  wire logic [3:0]  I_WB_SEL,           // byte selects
    input  wire logic [31:0] I_WB_ADR,           // byte address
    input  wire logic [31:0] I_WB_DAT,           // write data
    input  wire logic        I_EXT_PIN0_REQUEST, // pin 0 request, high
    input  wire logic        I_EXT_PIN1_REQUEST, // pin 1 request, high
    input  wire logic        I_TIMER0_OVERFLOW,  // timer0 flag
    input  wire logic        I_TIMER1_OVERFLOW,  // timer1 flag
    input  wire logic        I_TIMER2_OVERFLOW,  // timer2 flag
    input  wire logic        I_TIMER2_EXTERNAL_FLAG, // timer2 ext flag
    input  wire logic        I_SERIAL_TX_FLAG,   // serial tx flag
    input  wire logic        I_SERIAL_RX_FLAG,   // serial rx flag
    input  wire logic        I_CONVERSION_DONE,  // converter end, level
    input  wire logic        I_SERIAL_PERIPH_DONE, // one-cycle pulse
    input  wire logic        I_RECEIVER1_DATA_READY, // radio rx1 ready
    input  wire logic        I_RECEIVER2_DATA_READY, // radio rx2 ready
    input  wire logic        I_WAKEUP_EVENT,     // wakeup timer pulse
    output logic             O_WB_ACK,           // bus acknowledge
    output logic [31:0]      O_WB_DAT,           // read data
    output logic             O_IRQ_PENDING,      // some request pending
    output logic             O_IRQ_HIGH,         // winner is high level
    output logic [3:0]       O_IRQ_SOURCE        // winner natural index
);

    logic [7:0]  std_en_reg;
    logic [7:0]  std_lvl_reg;
    logic [3:0]  ext_flag_reg;
    logic        wake_flag_reg;
    logic [4:0]  ext_en_reg;
    logic [4:0]  ext_lvl_reg;
    logic [2:0]  edge_prev_reg;
    logic        ack_reg;
    logic [31:0] rdat_reg;
    logic        pend_reg;
    logic        high_reg;
    logic [3:0]  src_reg;

    logic        bus_req;
    logic        wr_stb;
    logic [7:0]  idx;
    logic [7:0]  wbyte;
    logic [2:0]  rise;
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] gate;
    logic [NUM_SRC-1:0] lvl;
    logic [NUM_SRC-1:0] req;
    logic [7:0]  rd_byte;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    assign bus_req = I_WB_CYC && I_WB_STB && !ack_reg;
    assign wr_stb  = bus_req && I_WB_WE && I_WB_SEL[0];
    assign idx     = I_WB_ADR[9:2];
    assign wbyte   = I_WB_DAT[7:0];

    // rising edges of the level-style event lines
    assign rise = {I_RECEIVER2_DATA_READY, I_RECEIVER1_DATA_READY,
                   I_CONVERSION_DONE} & ~edge_prev_reg;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            edge_prev_reg <= 3'h0;
        end else begin
            edge_prev_reg <= {I_RECEIVER2_DATA_READY,
                              I_RECEIVER1_DATA_READY, I_CONVERSION_DONE};
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            std_en_reg  <= RST_BYTE;
            std_lvl_reg <= RST_BYTE;
            ext_en_reg  <= RST_BYTE[4:0];
            ext_lvl_reg <= RST_BYTE[4:0];
        end else if (wr_stb) begin
            if (hit(idx, IDX_STANDARD_ENABLES))
                std_en_reg <= wbyte & STD_EN_WMASK;
            if (hit(idx, IDX_STANDARD_LEVELS))
                std_lvl_reg <= wbyte & STD_LVL_WMASK;
            if (hit(idx, IDX_EXTENDED_ENABLES))
                ext_en_reg <= wbyte[4:0];
            if (hit(idx, IDX_EXTENDED_LEVELS))
                ext_lvl_reg <= wbyte[4:0];
        end
    end

    // flags: hardware only sets, and a set in the clearing cycle wins
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ext_flag_reg <= RST_BYTE[3:0];
        end else begin
            ext_flag_reg <= ((wr_stb && hit(idx, IDX_EXTENDED_FLAGS))
                             ? wbyte[7:4] : ext_flag_reg)
                            | {rise[2], rise[1],
                               I_SERIAL_PERIPH_DONE,
                               rise[0]};
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wake_flag_reg <= 1'b0;
        end else begin
            wake_flag_reg <= ((wr_stb && hit(idx, IDX_WAKE_FLAG_CONTROL))
                              ? wbyte[POS_WAKE_FLAG] : wake_flag_reg)
                             | I_WAKEUP_EVENT;
        end
    end

    // sources in natural order: pin0 t0 pin1 t1 ser t2 conv sp rx1 rx2 wake
    assign raw = {wake_flag_reg, ext_flag_reg,
                  I_TIMER2_OVERFLOW | I_TIMER2_EXTERNAL_FLAG,
                  I_SERIAL_TX_FLAG | I_SERIAL_RX_FLAG,
                  I_TIMER1_OVERFLOW, I_EXT_PIN1_REQUEST,
                  I_TIMER0_OVERFLOW, I_EXT_PIN0_REQUEST};
    assign gate = {ext_en_reg,
                   std_en_reg[5], std_en_reg[4],
                   std_en_reg[3], std_en_reg[2],
                   std_en_reg[1], std_en_reg[0]};
    assign lvl  = {ext_lvl_reg, std_lvl_reg[5:0]};
    assign req  = raw & gate & {NUM_SRC{std_en_reg[POS_GLOBAL_GATE]}};

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pend_reg <= 1'b0;
            high_reg <= 1'b0;
            src_reg  <= NO_SOURCE;
        end else begin
            pend_reg <= |req;
            high_reg <= |(req & lvl);
            src_reg  <= NO_SOURCE;
            // downward loop so the lowest index is assigned last
            for (int i = NUM_SRC - 1; i >= 0; i--) begin
                if (|(req & lvl) ? (req[i] && lvl[i]) : req[i])
                    src_reg <= 4'(i);
            end
        end
    end

    always_comb begin
        case (idx)
            IDX_EXTENDED_FLAGS:
                rd_byte = {ext_flag_reg, 4'h0} | EXT_FLAG_ONES;
            IDX_STANDARD_ENABLES:  rd_byte = std_en_reg;
            IDX_STANDARD_LEVELS:   rd_byte = std_lvl_reg | STD_LVL_ONES;
            IDX_WAKE_FLAG_CONTROL:
                rd_byte = {4'h0, wake_flag_reg, 3'h0} | WAKE_ONES;
            IDX_EXTENDED_ENABLES:  rd_byte = {3'h0, ext_en_reg} | EXT_ONES;
            IDX_EXTENDED_LEVELS:   rd_byte = {3'h0, ext_lvl_reg} | EXT_ONES;
            IDX_PENDING_STATUS:
                rd_byte = {2'h0, high_reg, pend_reg, src_reg};
            default:               rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ack_reg  <= bus_req;
            rdat_reg <= bus_req ? {24'h0, rd_byte} : 32'h0;
        end
    end

    assign O_WB_ACK      = ack_reg;
    assign O_WB_DAT      = rdat_reg;
    assign O_IRQ_PENDING = pend_reg;
    assign O_IRQ_HIGH    = high_reg;
    assign O_IRQ_SOURCE  = src_reg;
endmodule

// [testbench/eir_src.sv]
`timescale 1ns/1ps
module eir_src (
    input  wire logic        i_clk, // cpu clock
    input  wire logic [12:0] i_set, // wanted request levels
    output logic      [12:0] o_src  // request lines to the block
);
    // peripherals change their lines just after the clock edge
    always_ff @(posedge i_clk) begin
        o_src <= i_set;
    end
endmodule

// [testbench/eir_top_bench.sv]
`timescale 1ns/1ps
module eir_top_bench;
    import eir_pkg::*;
    logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
    logic [3:0]  sel = 4'h1;
    logic [31:0] adr = 0, wdat = 0;
    logic [12:0] want = 0;
    wire  [12:0] s;
    wire  [31:0] rdat;
    wire  [3:0]  src;
    wire         ack, pend, high;
    int          fail_count = 0, checks = 0, k, b;
    logic [7:0]  rv, m;
    logic [7:0]  ix[6] = '{IDX_EXTENDED_FLAGS, IDX_STANDARD_ENABLES,
        IDX_STANDARD_LEVELS, IDX_WAKE_FLAG_CONTROL, IDX_EXTENDED_ENABLES,
        IDX_EXTENDED_LEVELS};
    logic [7:0]  wm[6] = '{EXT_FLAG_WMASK, STD_EN_WMASK, STD_LVL_WMASK,
        WAKE_WMASK, EXT_EN_WMASK, EXT_EN_WMASK};
    logic [7:0]  on[6] = '{EXT_FLAG_ONES, 8'h00, STD_LVL_ONES, WAKE_ONES,
        EXT_ONES, EXT_ONES};
    int          nat[13] = '{0, 1, 2, 3, 4, 4, 5, 5, 6, 7, 8, 9, 10};
    always #50 clk = ~clk;
    eir_src u_src (.i_clk(clk), .i_set(want), .o_src(s));
    eir_top u_dut (.I_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_ADR(adr),
        .I_WB_DAT(wdat), .I_EXT_PIN0_REQUEST(s[0]),
        .I_TIMER0_OVERFLOW(s[1]), .I_EXT_PIN1_REQUEST(s[2]),
        .I_TIMER1_OVERFLOW(s[3]), .I_SERIAL_TX_FLAG(s[4]),
        .I_SERIAL_RX_FLAG(s[5]), .I_TIMER2_OVERFLOW(s[6]),
        .I_TIMER2_EXTERNAL_FLAG(s[7]), .I_CONVERSION_DONE(s[8]),
        .I_SERIAL_PERIPH_DONE(s[9]), .I_RECEIVER1_DATA_READY(s[10]),
        .I_RECEIVER2_DATA_READY(s[11]), .I_WAKEUP_EVENT(s[12]),
        .O_WB_ACK(ack), .O_WB_DAT(rdat), .O_IRQ_PENDING(pend),
        .O_IRQ_HIGH(high), .O_IRQ_SOURCE(src));
    task automatic chk(input logic [7:0] seen, exp, input string nm);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one classic cycle; data taken at the edge that sees ack
    task automatic wb(input logic w, input logic [7:0] i, d,
                      output logic [7:0] q);
        int n;
        @(posedge clk);
        {cyc, stb, we} <= {2'h3, w};
        adr <= {22'h0, i, 2'h0};
        wdat <= {24'h0, d};
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
        if (ack !== 1'b1) begin
            fail_count++;
            summarize();
        end
        q = rdat[7:0];
        {cyc, stb} <= 2'h0;
    endtask
    initial begin
        void'($urandom(32'hcbc4));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (k = 0; k < 6; k++) begin
            wb(0, ix[k], 0, rv);
            chk(rv, on[k], "reset value");
            m = 8'($urandom);
            wb(1, ix[k], m, rv);
            wb(0, ix[k], 0, rv);
            chk(rv, m & wm[k] | on[k], "readback");
            wb(1, ix[k], 0, rv);
        end
        wb(0, 8'h10, 0, rv);
        chk(rv, 8'h00, "unmapped");
        $display("registers done");
        wb(1, IDX_STANDARD_ENABLES, 8'hbf, rv);
        wb(1, IDX_EXTENDED_ENABLES, 8'h1f, rv);
        for (k = 0; k < 13; k++) begin
            want[k] <= 1'b1;
            @(posedge clk);
            if (k >= 8) want[k] <= 1'b0;
            repeat (4) @(posedge clk);
            chk(8'(src), 8'(nat[k]), "winner");
            want[k] <= 1'b0;
            repeat (4) @(posedge clk);
            chk(8'(pend), 8'(k >= 8), "held");
            wb(1, IDX_EXTENDED_FLAGS, 0, rv);
            wb(1, IDX_WAKE_FLAG_CONTROL, 0, rv);
        end
        $display("sources done");
        wb(1, IDX_WAKE_FLAG_CONTROL, 8'h08, rv);
        repeat (3) @(posedge clk);
        chk(8'(src), 8'h0a, "soft wake");
        wb(1, IDX_EXTENDED_FLAGS, 8'h80, rv);
        repeat (3) @(posedge clk);
        chk(8'(src), 8'h09, "soft flag");
        wb(1, IDX_EXTENDED_LEVELS, 8'h10, rv);
        repeat (3) @(posedge clk);
        chk({high, src}, 8'h1a, "wake high");
        wb(0, IDX_PENDING_STATUS, 8'h00, rv);
        chk(rv, 8'h3a, "status");
        wb(1, IDX_EXTENDED_LEVELS, 8'h08, rv);
        repeat (3) @(posedge clk);
        chk({high, src}, 8'h19, "ext high");
        // radio2 flag is still set; drop its high level so it cannot win
        wb(1, IDX_EXTENDED_LEVELS, 8'h00, rv);
        want <= 13'h00ff;
        for (k = 0; k < 4; k++) begin
            m = 8'($urandom) & 8'h3f;
            wb(1, IDX_STANDARD_LEVELS, m, rv);
            repeat (3) @(posedge clk);
            b = 0;
            while (m != 0 && !m[b]) b++;
            chk({high, src}, {4'(m != 0), 4'(b)}, "priority");
        end
        wb(1, IDX_STANDARD_ENABLES, 8'h3f, rv);
        repeat (3) @(posedge clk);
        chk(8'(pend), 8'h00, "global off");
        $display("priority done");
        summarize();
    end
endmodule

// [testbench/eir_top_props.sv]
`timescale 1ns/1ps
module eir_props
    import eir_pkg::*;
(
    input wire logic        I_CLK,         // clock
    input wire logic        I_RSTN,        // reset, low
    input wire logic        I_WB_CYC,      // bus cycle
    input wire logic        I_WB_STB,      // strobe
    input wire logic        I_WB_WE,       // write
    input wire logic [3:0]  I_WB_SEL,      // byte selects
    input wire logic [31:0] I_WB_ADR,      // address
    input wire logic [31:0] I_WB_DAT,      // write data
    input wire logic        O_WB_ACK,      // ack
    input wire logic [31:0] O_WB_DAT,      // read data
    input wire logic        O_IRQ_PENDING, // pending
    input wire logic [3:0]  O_IRQ_SOURCE   // winner
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    wire       take = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    wire       rd   = O_WB_ACK && !I_WB_WE;
    wire [7:0] ix   = I_WB_ADR[9:2];
    property p_ack; take |=> O_WB_ACK; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_ack_one; O_WB_ACK |=> !O_WB_ACK; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_flag_rsv;
        rd && ix == IDX_EXTENDED_FLAGS |-> O_WB_DAT[3:0] == 4'h8;
    endproperty
    a_flag_rsv: assert property (p_flag_rsv) else $error("flag bits");
    property p_wake_rsv;
        rd && ix == IDX_WAKE_FLAG_CONTROL |-> O_WB_DAT[6:4] == 3'h4
            && O_WB_DAT[2:0] == 3'h0;
    endproperty
    a_wake_rsv: assert property (p_wake_rsv) else $error("wake bits");
    property p_ext_rsv;
        rd && (ix == IDX_EXTENDED_ENABLES || ix == IDX_EXTENDED_LEVELS)
            |-> O_WB_DAT[7:5] == 3'h7;
    endproperty
    a_ext_rsv: assert property (p_ext_rsv) else $error("ext bits");
    property p_lvl_rsv;
        rd && ix == IDX_STANDARD_LEVELS |-> O_WB_DAT[7:6] == 2'h2;
    endproperty
    a_lvl_rsv: assert property (p_lvl_rsv) else $error("level bits");
    property p_gate;
        take && I_WB_WE && I_WB_SEL[0] && ix == IDX_STANDARD_ENABLES
            && !I_WB_DAT[7] |=> ##1 !O_IRQ_PENDING;
    endproperty
    a_gate: assert property (p_gate) else $error("gate leak");
    property p_pend; O_IRQ_PENDING == (O_IRQ_SOURCE != NO_SOURCE); endproperty
    a_pend: assert property (p_pend) else $error("pending vs source");
endmodule
bind eir_top eir_props u_props (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
    .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
    .I_WB_SEL(I_WB_SEL), .I_WB_ADR(I_WB_ADR), .I_WB_DAT(I_WB_DAT),
    .O_WB_ACK(O_WB_ACK), .O_WB_DAT(O_WB_DAT),
    .O_IRQ_PENDING(O_IRQ_PENDING), .O_IRQ_SOURCE(O_IRQ_SOURCE));
